/* rtl/stlf_defines.vh */
// Constants for the sensor timing logic block: register map, fields, modes and timing.
`ifndef STLF_DEFINES_VH
`define STLF_DEFINES_VH
`define STLF_ADDR_W 4
`define STLF_REG_CTRL 4'h0
`define STLF_REG_DELAY 4'h4
`define STLF_REG_HOLD 4'h8
`define STLF_REG_STAT 4'hC
`define STLF_CTRL_RST 32'h0000_0000
`define STLF_DELAY_RST 4'h1
`define STLF_HOLD_RST 4'h1
`define STLF_MODE_LSB 0
`define STLF_MODE_MSB 3
`define STLF_DARK_BIT 4
`define STLF_NC_BIT 5
`define STLF_RANGE_LSB 6
`define STLF_RANGE_MSB 7
`define STLF_SET_W 4
`define STLF_SET_MAX 4'hE
`define STLF_RANGE_SHORT 2'h0
`define STLF_RANGE_MID 2'h1
`define STLF_RANGE_LONG 2'h2
`define STLF_TICK_NS_SHORT 10000000
`define STLF_TICK_NS_MID 100000000
`define STLF_TICK_NS_LONG 1000000000
`define STLF_CLK_NS 10
`define STLF_M_ONOFF 4'h0
`define STLF_M_ONDLY 4'h1
`define STLF_M_OFFDLY 4'h2
`define STLF_M_ONOFFDLY 4'h3
`define STLF_M_ONESHOT 4'h4
`define STLF_M_DLYSHOT 4'h5
`define STLF_M_LIMIT 4'h6
`define STLF_M_REPEAT 4'h7
`define STLF_M_ACLATCH 4'h8
`define STLF_M_DCLATCH 4'h9
`define STLF_M_DLYLATCH 4'hA
`define STLF_M_LIMLATCH 4'hB
`define STLF_RESP_OKAY 2'h0
`define STLF_RESP_SLVERR 2'h2
`endif

/* rtl/stlf_timing_logic.v */
// Sensor timing logic: twelve delay, pulse and latch functions behind an AXI4-Lite register port.
`timescale 1ns/1ps
`include "stlf_defines.vh"
// Functional notes
// R01: Twelve selectable timing functions with delay, pulse and latch, single or dual timing.
// R02: Light-operate or dark-operate selects which sensed level counts as input present.
// R03: Delay and hold share one range: 10-150 ms, 0.1-1.5 s or 1-15 s.
// R04: Output polarity setting selects normally open or normally closed output.
// R05: On/off passes input straight through; inhibit forces output off.
// R06: On delay turns on after continuous input for delay; interruption resets timer.
// R07: On delay: inhibit cancels output at once and clears the delay timer.
// R08: On delay: releasing inhibit with input present restarts timing from zero.
// R09: Off delay: on at once, off after hold of absence; inhibit blocks start.
// R10: On and off delay uses delay then hold; momentary inhibit restarts the delay.
// R11: On and off delay: inhibit during output lets the hold time finish.
// R12: One-shot emits hold-long pulse on the active-going input edge.
// R13: One-shot: inhibit blocks new triggers but never shortens a running pulse.
// R14: Delayed one-shot: edge starts delay then hold pulse; rearm needs input removal.
// R15: Delayed one-shot: inhibit during delay aborts; a running pulse completes.
// R16: Limit: output follows input but turns off after hold; removal clears timer.
// R17: Limit: inhibit cancels output; release with input present restarts timer.
// R18: Repeat cycle alternates delay off and hold on; removal finishes the on period.
// R19: Repeat cycle: inhibit stops cycling but lets a running hold period finish.
// R20: AC latch sets on input edge; inhibit clears; relatch needs input reapplied.
// R21: DC latch is on while input present; inhibit forces off, relatches on release.
// R22: Delay and latch latches after delay; input loss or inhibit resets timing.
// R23: Limit and latch: expired limit latches off until an inhibit pulse resets it.
// R24: External controller asserts inhibit by pulling the auxiliary input low.
// R25: Inputs are synchronised; all timing comes from a prescaled tick counter.
// R26: After reset output is off, timers clear and latches reset.
module stlf_timing_logic #(
    parameter CLK_NS = `STLF_CLK_NS,
    parameter TICK_NS_SHORT = `STLF_TICK_NS_SHORT,
    parameter TICK_NS_MID = `STLF_TICK_NS_MID,
    parameter TICK_NS_LONG = `STLF_TICK_NS_LONG
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`STLF_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [`STLF_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    input wire sensor_light,
    input wire aux_inhibit_n,
    output reg relay_out
);
    // Tick periods per range in clock cycles; one tick is a fifteenth-of-range step unit.
    localparam [31:0] DIV_SHORT = TICK_NS_SHORT / CLK_NS;
    localparam [31:0] DIV_MID = TICK_NS_MID / CLK_NS;
    localparam [31:0] DIV_LONG = TICK_NS_LONG / CLK_NS;
    // Phase codes, one-hot.
    localparam [4:0] PH_IDLE = 5'h01;
    localparam [4:0] PH_DLY = 5'h02;
    localparam [4:0] PH_ON = 5'h04;
    localparam [4:0] PH_HOLD = 5'h08;
    localparam [4:0] PH_LOCK = 5'h10;

    reg [31:0] ctrl_q;
    reg [`STLF_SET_W-1:0] delay_q;
    reg [`STLF_SET_W-1:0] hold_q;
    reg [3:0] awaddr_q;
    reg aw_got_q;
    reg w_got_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [2:0] sen_sync_q;
    reg [2:0] inh_sync_q;
    reg sen_q;
    reg inh_q;
    reg present_prev_q;
    reg [31:0] pre_q;
    reg [`STLF_SET_W:0] cnt_q;
    reg [4:0] ph_q;
    reg [4:0] ph_d;
    reg [`STLF_SET_W:0] cnt_d;
    reg clr_pre;
    reg logic_out;
    reg [31:0] div_sel;

    wire [3:0] mode = ctrl_q[`STLF_MODE_MSB:`STLF_MODE_LSB];
    wire [1:0] range = ctrl_q[`STLF_RANGE_MSB:`STLF_RANGE_LSB];
    wire present = sen_q ^ ctrl_q[`STLF_DARK_BIT]; // see R02
    wire rise = present & ~present_prev_q;
    // The tick is not masked by clr_pre: clr_pre itself depends on the tick, and masking would loop.
    wire tick = (pre_q == div_sel - 32'h0000_0001);
    wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

    // Only the low four bits are kept and a zero setting is raised to one, so the timer always ends in range.
    function [`STLF_SET_W-1:0] clamp_set;
        input [31:0] v;
        begin
            if (v[`STLF_SET_W-1:0] == 4'h0) begin
                clamp_set = 4'h1;
            end else begin
                clamp_set = v[`STLF_SET_W-1:0];
            end
        end
    endfunction

    // Merge byte lane 0 of a write into a stored word.
    function [31:0] merge_lane;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        begin
            merge_lane = old;
            if (strb[0]) begin
                merge_lane[7:0] = nw[7:0];
            end
        end
    endfunction

    // Select the prescaler divide for the programmed range.
    always @* begin // see R03
        case (range)
            `STLF_RANGE_SHORT: div_sel = DIV_SHORT;
            `STLF_RANGE_MID: div_sel = DIV_MID;
            default: div_sel = DIV_LONG;
        endcase
    end

    // Three-stage synchronisers; a change is taken only when stages two and three agree.
    always @(posedge aclk) begin // see R25
        if (!aresetn) begin
            sen_sync_q <= 3'h0;
            inh_sync_q <= 3'h0;
            sen_q <= 1'b0;
            inh_q <= 1'b0;
        end else begin
            sen_sync_q <= {sen_sync_q[1:0], sensor_light};
            inh_sync_q <= {inh_sync_q[1:0], ~aux_inhibit_n}; // see R24
            if (sen_sync_q[1] == sen_sync_q[2]) begin
                sen_q <= sen_sync_q[2];
            end
            if (inh_sync_q[1] == inh_sync_q[2]) begin
                inh_q <= inh_sync_q[2];
            end
        end
    end

    // Write channel: address and data are taken in either order, response follows both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STLF_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            ctrl_q <= `STLF_CTRL_RST;
            delay_q <= `STLF_DELAY_RST;
            hold_q <= `STLF_HOLD_RST;
        end else begin
            s_axi_awready <= ~aw_got_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_got_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `STLF_RESP_OKAY;
                case ({awaddr_q[3:2], 2'b00})
                    `STLF_REG_CTRL: ctrl_q <= merge_lane(ctrl_q, wdata_q, wstrb_q); // see R01
                    `STLF_REG_DELAY: delay_q <= clamp_set(merge_lane({28'h0, delay_q}, wdata_q, wstrb_q));
                    `STLF_REG_HOLD: hold_q <= clamp_set(merge_lane({28'h0, hold_q}, wdata_q, wstrb_q));
                    default: s_axi_bresp <= `STLF_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, status shows live input, inhibit, phase and output.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `STLF_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `STLF_RESP_OKAY;
                case ({s_axi_araddr[3:2], 2'b00})
                    `STLF_REG_CTRL: s_axi_rdata <= {24'h0, ctrl_q[7:0]};
                    `STLF_REG_DELAY: s_axi_rdata <= {28'h0, delay_q};
                    `STLF_REG_HOLD: s_axi_rdata <= {28'h0, hold_q};
                    `STLF_REG_STAT: s_axi_rdata <= {19'h0, cnt_q, ph_q, present, inh_q, relay_out};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `STLF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Mode engine: each function is a walk through some of the idle, delay, on, hold and lock phases.
    // The timer restarts whenever a phase begins, so partial ticks never shorten a period.
    always @* begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        clr_pre = 1'b0;
        case (mode)
            `STLF_M_ONOFF, `STLF_M_DCLATCH: begin // see R05, R21
                ph_d = (present & ~inh_q) ? PH_ON : PH_IDLE;
            end
            `STLF_M_ONDLY, `STLF_M_DLYLATCH: begin // see R06, R07, R08, R22
                if (inh_q | (~present & ((mode == `STLF_M_ONDLY) | ~ph_q[2]))) begin
                    ph_d = PH_IDLE;
                end else if (ph_q[0]) begin
                    ph_d = PH_DLY;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end else if (ph_q[1] & tick & (cnt_q + 5'h01 >= {1'b0, delay_q})) begin
                    ph_d = PH_ON;
                end
            end
            `STLF_M_OFFDLY, `STLF_M_ONOFFDLY: begin // see R09, R10, R11
                if (ph_q[2] | ph_q[3]) begin
                    if (present & ~inh_q) begin
                        ph_d = PH_ON;
                    end else if (ph_q[2]) begin
                        ph_d = PH_HOLD;
                        clr_pre = 1'b1;
                        cnt_d = 5'h00;
                    end else if (tick & (cnt_q + 5'h01 >= {1'b0, hold_q})) begin
                        ph_d = PH_IDLE;
                    end
                end else if (inh_q | ~present) begin
                    ph_d = PH_IDLE;
                end else if (mode == `STLF_M_OFFDLY) begin
                    ph_d = PH_ON;
                end else if (ph_q[0]) begin
                    ph_d = PH_DLY;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end else if (tick & (cnt_q + 5'h01 >= {1'b0, delay_q})) begin
                    ph_d = PH_ON;
                end
            end
            `STLF_M_ONESHOT, `STLF_M_DLYSHOT: begin // see R12, R13, R14, R15
                if (ph_q[3]) begin
                    if (tick & (cnt_q + 5'h01 >= {1'b0, hold_q})) begin
                        ph_d = PH_LOCK;
                    end
                end else if (ph_q[1]) begin
                    if (inh_q) begin
                        ph_d = PH_LOCK;
                    end else if (tick & (cnt_q + 5'h01 >= {1'b0, delay_q})) begin
                        ph_d = PH_HOLD;
                        clr_pre = 1'b1;
                        cnt_d = 5'h00;
                    end
                end else if (rise & ~inh_q) begin
                    ph_d = (mode == `STLF_M_ONESHOT) ? PH_HOLD : PH_DLY;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end else if (~present) begin
                    ph_d = PH_IDLE;
                end
            end
            `STLF_M_LIMIT, `STLF_M_LIMLATCH: begin // see R16, R17, R23
                if (inh_q) begin
                    ph_d = PH_IDLE;
                end else if (ph_q[4]) begin
                    ph_d = ((mode == `STLF_M_LIMIT) & ~present) ? PH_IDLE : PH_LOCK;
                end else if (~present) begin
                    ph_d = PH_IDLE;
                end else if (ph_q[0]) begin
                    ph_d = PH_HOLD;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end else if (tick & (cnt_q + 5'h01 >= {1'b0, hold_q})) begin
                    ph_d = PH_LOCK;
                end
            end
            `STLF_M_REPEAT: begin // see R18, R19
                if (ph_q[3]) begin
                    if (tick & (cnt_q + 5'h01 >= {1'b0, hold_q})) begin
                        ph_d = (present & ~inh_q) ? PH_DLY : PH_IDLE;
                        clr_pre = 1'b1;
                        cnt_d = 5'h00;
                    end
                end else if (inh_q | ~present) begin
                    ph_d = PH_IDLE;
                end else if (ph_q[0]) begin
                    ph_d = PH_DLY;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end else if (tick & (cnt_q + 5'h01 >= {1'b0, delay_q})) begin
                    ph_d = PH_HOLD;
                    clr_pre = 1'b1;
                    cnt_d = 5'h00;
                end
            end
            `STLF_M_ACLATCH: begin // see R20
                if (inh_q) begin
                    ph_d = PH_LOCK;
                end else if (ph_q[2]) begin
                    ph_d = PH_ON;
                end else if (rise) begin
                    ph_d = PH_ON;
                end else if (~present) begin
                    ph_d = PH_IDLE;
                end
            end
            default: ph_d = PH_IDLE;
        endcase
        if (tick & ~clr_pre & (ph_d == ph_q)) begin
            cnt_d = cnt_q + 5'h01;
        end
        if (ph_d != ph_q) begin
            clr_pre = 1'b1;
            cnt_d = 5'h00;
        end
    end

    // Output decode on the next phase, so the relay flop moves together with the phase register.
    // Limit modes time their on period in the hold phase and never drive from the on phase.
    always @* begin
        logic_out = ph_d[2] | ph_d[3];
        if (((mode == `STLF_M_LIMIT) | (mode == `STLF_M_LIMLATCH)) & ph_d[2]) begin
            logic_out = 1'b0;
        end
    end

    // Prescaler, step counter, phase register and output flop.
    always @(posedge aclk) begin // see R26
        if (!aresetn) begin
            pre_q <= 32'h0000_0000;
            cnt_q <= 5'h00;
            ph_q <= PH_IDLE;
            present_prev_q <= 1'b1;
            relay_out <= 1'b0;
        end else begin
            if (clr_pre | tick) begin // see R25
                pre_q <= 32'h0000_0000;
            end else begin
                pre_q <= pre_q + 32'h0000_0001;
            end
            cnt_q <= cnt_d;
            ph_q <= ph_d;
            present_prev_q <= present;
            relay_out <= logic_out ? ~ctrl_q[`STLF_NC_BIT] : ctrl_q[`STLF_NC_BIT]; // see R04
        end
    end
endmodule // stlf_timing_logic

/* tb/stlf_props.sv */
// Checker for the sensor timing block: relay behaviour against its inputs and the snooped control word.
`timescale 1ns/1ps
`include "stlf_defines.vh"
module stlf_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [`STLF_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire sensor_light,
    input wire aux_inhibit_n,
    input wire relay_out
);
    reg [`STLF_ADDR_W-1:0] addr_q;
    reg [31:0] data_q;
    reg [7:0] ctrl_q;
    wire [3:0] mode = ctrl_q[3:0];
    wire nc = ctrl_q[5];
    wire present = sensor_light ^ ctrl_q[4];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Mirror of the control word; it lags the design by a cycle, so every window below is longer than that lag.
    always @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= {`STLF_ADDR_W{1'b0}};
            data_q <= 32'h0;
            ctrl_q <= 8'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) addr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) data_q <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && addr_q == `STLF_REG_CTRL)
                ctrl_q <= data_q[7:0];
        end
    end
    property p_reset_off;
        $rose(aresetn) |-> relay_out == 1'b0;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("relay not off after reset");
    property p_onoff_follow;
        (mode == 4'h0 && aux_inhibit_n && $stable(present) && $stable(ctrl_q))[*8] |-> relay_out == (present ^ nc);
    endproperty
    a_onoff_follow: assert property (p_onoff_follow) else $error("pass mode output wrong");
    property p_onoff_inh;
        (mode == 4'h0 && $fell(aux_inhibit_n)) ##1 (!aux_inhibit_n && $stable(ctrl_q))[*6] |-> relay_out == nc;
    endproperty
    a_onoff_inh: assert property (p_onoff_inh) else $error("pass mode not forced off");
    property p_ondly_wait;
        (mode == 4'h1 && ctrl_q == $past(ctrl_q, 3) && $rose(relay_out ^ nc)) |-> $past(present, 6) && $past(aux_inhibit_n, 6);
    endproperty
    a_ondly_wait: assert property (p_ondly_wait) else $error("on delay output too early");
    property p_ondly_inh;
        (mode == 4'h1 && !aux_inhibit_n && $stable(ctrl_q))[*6] |-> relay_out == nc;
    endproperty
    a_ondly_inh: assert property (p_ondly_inh) else $error("on delay not cancelled");
    property p_offdly_inh;
        (mode == 4'h2 && relay_out == nc && !aux_inhibit_n && $past(aux_inhibit_n, 5) == 1'b0) |=> relay_out == nc;
    endproperty
    a_offdly_inh: assert property (p_offdly_inh) else $error("off delay started while held");
    property p_dclatch_inh;
        (mode == 4'h9 && !aux_inhibit_n && $stable(ctrl_q))[*6] |-> relay_out == nc;
    endproperty
    a_dclatch_inh: assert property (p_dclatch_inh) else $error("level latch not forced off");
    property p_limlatch_inh;
        mode == 4'hB && !aux_inhibit_n && $past(aux_inhibit_n, 6) == 1'b0 && $past(ctrl_q, 6) == ctrl_q |-> relay_out == nc;
    endproperty
    a_limlatch_inh: assert property (p_limlatch_inh) else $error("limit latch not held off");
endmodule // stlf_props
bind stlf_timing_logic stlf_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .sensor_light(sensor_light),
    .aux_inhibit_n(aux_inhibit_n), .relay_out(relay_out));

/* tb/stlf_sensor_model.sv */
// Behavioural model of the amplifier output stage and the external sinking contact on the inhibit pin.
`timescale 1ns/1ps
module stlf_sensor_model (
    input wire aclk,
    input wire beam_req,
    input wire sink_req,
    output reg sensor_light,
    output reg aux_inhibit_n
);
    // The amplifier answers one clock late; the contact only ever pulls low, the pull-up does the rest.
    initial sensor_light = 1'b0;
    initial aux_inhibit_n = 1'b1;
    always @(posedge aclk) begin
        sensor_light <= beam_req;
        aux_inhibit_n <= ~sink_req;
    end
endmodule // stlf_sensor_model

/* tb/testbench.sv */
// Self-checking bench for the sensor timing block: register access and every timing function.
`timescale 1ns/1ps
`include "stlf_defines.vh"
module testbench;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [`STLF_ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg beam_req = 1'b0, sink_req = 1'b0, relay_chk = 1'b0;
    reg [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sensor_light, aux_inhibit_n, relay_out;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic [33:0] exp_q[$];
    logic [3:0] rnd_steps;
    int err_total = 0;
    int checks = 0;
    int test_no = 0;
    // Short tick periods: one step is 10, 20 or 40 clocks for the three ranges.
    stlf_timing_logic #(.TICK_NS_SHORT(100), .TICK_NS_MID(200), .TICK_NS_LONG(400)) dut_u (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .sensor_light(sensor_light), .aux_inhibit_n(aux_inhibit_n), .relay_out(relay_out));
    stlf_sensor_model model_u (.aclk(aclk), .beam_req(beam_req), .sink_req(sink_req), .sensor_light(sensor_light),
        .aux_inhibit_n(aux_inhibit_n));
    always #5 aclk = ~aclk;
    // Compares a seen value against the oldest queued expectation.
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        begin
            checks++;
            if (seen !== exp) begin
                err_total++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // Watcher: each response or relay sample takes one note off the queue.
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (relay_chk) check({33'h0, relay_out}, exp_q.pop_front());
    end
    // One bus transfer; valid and payload stay put until their own ready, and the answer is awaited unbounded.
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [33:0] exp);
        logic done;
        begin
            done = 1'b0;
            exp_q.push_back(exp);
            if (wr) begin
                s_axi_awaddr <= a;
                s_axi_wdata <= d;
                s_axi_awvalid <= 1'b1;
                s_axi_wvalid <= 1'b1;
                s_axi_bready <= 1'b1;
            end else begin
                s_axi_araddr <= a;
                s_axi_arvalid <= 1'b1;
                s_axi_rready <= 1'b1;
            end
            while (!done) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                done = wr ? s_axi_bvalid : s_axi_rvalid;
            end
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    // Script player: Mhh writes the control word, L and I set beam and inhibit, Wdd waits, C samples the relay.
    task automatic run(input string s);
        int i;
        begin
            i = 0;
            while (i < s.len()) begin
                case (s[i])
                    "L": beam_req <= (s[i+1] == "1");
                    "I": sink_req <= (s[i+1] == "1");
                    "W": repeat (s.substr(i + 1, i + 2).atoi()) @(posedge aclk);
                    "M": axi(1'b1, `STLF_REG_CTRL, 32'(s.substr(i + 1, i + 2).atohex()), 34'h0);
                    default: begin
                        exp_q.push_back({33'h0, s[i+1] == "1"});
                        relay_chk <= 1'b1;
                        @(posedge aclk);
                        relay_chk <= 1'b0;
                    end
                endcase
                i = i + ((s[i] == "W" || s[i] == "M") ? 3 : 2);
            end
            test_no++;
            $display("test %0d done", test_no);
        end
    endtask
    task automatic report_and_stop;
        begin
            $display("checks=%0d err_total=%0d", checks, err_total);
            if (err_total == 0 && checks > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    // Watchdog sized at several times the expected run of about three thousand clocks.
    initial begin
        #300000;
        err_total++;
        report_and_stop();
    end
    // Main sequence: registers first, then each timing function with delay and hold at three steps.
    initial begin
        void'($urandom(32'hDC2F));
        rnd_steps = 4'($urandom_range(14, 1));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(1'b0, `STLF_REG_CTRL, 32'h0, 34'h0);
        axi(1'b1, `STLF_REG_DELAY, {28'h0, rnd_steps}, 34'h0);
        s_axi_wstrb <= 4'h0;
        axi(1'b1, `STLF_REG_DELAY, 32'hF, 34'h0);
        s_axi_wstrb <= 4'hF;
        axi(1'b0, `STLF_REG_DELAY, 32'h0, {30'h0, rnd_steps});
        axi(1'b1, `STLF_REG_STAT, 32'h0, 34'h2);
        axi(1'b1, `STLF_REG_DELAY, 32'h3, 34'h0);
        axi(1'b1, `STLF_REG_HOLD, 32'h3, 34'h0);
        run("M00W30L1W15C1I1W10C0I0L0W10C0");
        run("M10W30C1L1W15C0L0");
        run("M20W30C1L1W15C0L0");
        run("M01W30L1W15C0W35C1I1W10C0I0W15C0W35C1L0W10C0");
        run("L1W20L0W05L1W20C0W40C1L0W10");
        run("M02W30L1W10C1L0W15C1W35C0I1L1W15C0L0I0W10");
        run("M03W30L1W15C0W35C1I1W15C1W35C0I0L0W30L1W20I1W05I0W25C0W40C1L0W50");
        run("M04W30L1W15C1W50C0L0W10I1L1W15C0L0I0W10L1W15I1W05C1W45C0I0L0W10");
        run("M05W30L1W15C0W35C1W40C0W40C0L0W10L1W15I1W05I0W60C0L0W10");
        run("M06W30L1W15C1W45C0L0W10L1W10I1W10C0I0W15C1W45C0L0W10");
        run("M07W30L1W15C0W35C1W30C0W22C1L0W50C0L1W40I1W10C1W20C0W40C0I0L0W10");
        run("M08W30L1W10C1W50C1I1W10C0I0W10C0L0W10L1W10C1L0I1W10I0W10");
        run("M09W30L1W10C1I1W10C0I0W10C1L0I1W10I0W10");
        run("M0AW30L1W15C0W35C1L0W20C1I1W10C0I0W10");
        run("M0BW30L1W15C1W45C0L0W20L1W20C0I1W10C0I0W15C1L0I1W10I0W10");
        run("M0FW30L1W15C0L0W10");
        run("M41W30L1W40C0W50C1L0W10");
        run("M81W30L1W70C0W70C1L0W10");
        report_and_stop();
    end
endmodule // testbench
